// File: hdl/rct_pkg.sv
/*
 * Package for the reload/capture timer: register offsets, field positions,
 * reset values and the count-rate divider.
 * Assumes a single 100 MHz peripheral clock and a plain register port.
 */
package rct_pkg;
	// Register offsets on the plain register port.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_RELOAD = 4'h1;
	localparam logic [3:0] ADDR_COUNT_LO = 4'h2;
	localparam logic [3:0] ADDR_COUNT_HI = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	// Control register field positions.
	localparam int CTRL_RUN = 0;
	localparam int CTRL_CAPTURE = 1;
	localparam int CTRL_UPDOWN = 2;
	localparam int CTRL_EXT_EN = 3;
	localparam int CTRL_EDGE_RISE = 4;
	localparam int CTRL_PRESCALE = 5;
	localparam int CTRL_WIDTH = 6;
	// Status register field positions.
	localparam int STAT_RELOAD = 0;
	localparam int STAT_CAPTURE = 1;
	localparam int STAT_DIR_UP = 2;
	// Values after reset.
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	// Fixed counter limits.
	localparam logic [15:0] COUNT_TOP = 16'hffff;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	// Count tick every twelve clocks with the prescaler off.
	localparam int TICK_DIV = 12;
	// Tick divider when the prescaler is on (a plain choice).
	localparam int TICK_DIV_PRE = 24;
	localparam int DIV_WIDTH = 5;
	localparam logic [DIV_WIDTH-1:0] DIV_RESET = 5'h00;
endpackage

// File: hdl/rct_pin_if.sv
/*
 * Interface carrying the conditioned external input from the pin
 * conditioner to the timer core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface rct_pin_if;
	logic level;
	logic rise;
	logic fall;
	modport source (output level, output rise, output fall);
	modport sink (input level, input rise, input fall);
endinterface

// File: hdl/rct_pin_sync.sv
/*
 * Three-stage synchroniser and edge detector for the external timer input.
 * Assumes the pin is asynchronous to the clock.
 */
`timescale 1ns/1ps
module rct_pin_sync (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_reset,
	// Raw pin.
	input wire logic i_pin,
	// Conditioned outputs.
	rct_pin_if.source o_pin
);
	logic stage1;
	logic stage2;
	logic stage3;
	logic stable;

	// The first stage is only read by the second, so metastability cannot spread.
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			stable <= 1'b0;
		end else begin
			stage1 <= i_pin;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				stable <= stage3;
			end
		end
	end

	// A change counts once the last two stages agree.
	assign o_pin.level = stable;
	assign o_pin.rise = (stage2 == stage3) && stage3 && !stable;
	assign o_pin.fall = (stage2 == stage3) && !stage3 && stable;
endmodule

// File: hdl/rct_timer.sv
/*
 * Reload/capture timer: 16-bit counter with auto-reload (up or up/down)
 * and single-channel capture modes, register port and interrupt request.
 * Assumes one 100 MHz clock, a synchronous active-high reset and a register
 * master that never issues read and write strobes together.
 */
// How it works
// - One 16-bit counter with only auto-reload and capture modes.
// - With prescaler off the counter advances once every twelve clocks.
// - Counting runs continuously while enabled; never self-stops.
// - Auto-reload, up only: count up from reload value, overflow past FFFF.
// - Reload on overflow, or optionally also on the chosen external edge.
// - Auto-reload reloads from the reload/capture register.
// - Auto-reload up-only raises an interrupt on every reload.
// - Up/down mode takes direction from the external input level.
// - Up/down mode never raises an interrupt.
// - Up/down counting up reloads from the register after FFFF.
// - Up/down counting down underflows on reaching the register value.
// - Underflow reloads the counter with FFFF.
// - Capture mode counts up from 0000, overflow reloads 0000.
// - Capture mode triggers capture on the chosen external edge.
// - Capture copies the counter into the reload/capture register.
// - Capture mode interrupts on every reload and every capture.
// - Counter readable as low byte and high byte.
`timescale 1ns/1ps
module rct_timer #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	// Register port.
	input wire logic [3:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WRITE,
	input wire logic I_READ,
	output logic [15:0] O_RDATA,
	// External timer input pin.
	input wire logic I_TIMER_EXTERNAL_INPUT,
	// Interrupt request, registered irq_evt: high one cycle for each cycle with an event; events in the same cycle share one pulse.
	output logic O_IRQ,
	// Current count value.
	output logic [WIDTH-1:0] O_TIMER_COUNT_VALUE
);
	localparam int DIV_WIDTH_L = rct_pkg::DIV_WIDTH;
	localparam logic [DIV_WIDTH_L-1:0] DIV_LAST =
		DIV_WIDTH_L'(rct_pkg::TICK_DIV - 1);
	localparam logic [DIV_WIDTH_L-1:0] DIV_LAST_PRE =
		DIV_WIDTH_L'(rct_pkg::TICK_DIV_PRE - 1);
	localparam logic [WIDTH-1:0] TOP = WIDTH'(rct_pkg::COUNT_TOP);
	localparam logic [WIDTH-1:0] ZERO = WIDTH'(rct_pkg::COUNT_ZERO);

	// Divider state machine: counting the tick or idle.
	typedef enum logic [1:0] {
		RCT_IDLE = 2'b01,
		RCT_RUN = 2'b10
	} rct_state_t;

	rct_pin_if pin ();

	logic [5:0] ctrl;
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] reload;
	logic [DIV_WIDTH_L-1:0] div;
	rct_state_t state;
	rct_state_t next_state;
	logic sticky_reload;
	logic sticky_capture;

	wire run = ctrl[rct_pkg::CTRL_RUN];
	wire capture_mode = ctrl[rct_pkg::CTRL_CAPTURE];
	wire updown = ctrl[rct_pkg::CTRL_UPDOWN] && !capture_mode;
	wire ext_en = ctrl[rct_pkg::CTRL_EXT_EN];
	wire edge_rise = ctrl[rct_pkg::CTRL_EDGE_RISE];
	wire prescale = ctrl[rct_pkg::CTRL_PRESCALE];

	// Edge and direction decode from the conditioned pin.
	wire ext_edge = edge_rise ? pin.rise : pin.fall;
	wire dir_up = !updown || pin.level;
	wire [DIV_WIDTH_L-1:0] div_last = prescale ? DIV_LAST_PRE : DIV_LAST;
	wire tick = (state == RCT_RUN) && (div == div_last);

	// Counting events for the current mode.
	wire overflow = tick && dir_up && (count == TOP);
	wire underflow = tick && !dir_up && (count == reload);
	wire edge_reload = !capture_mode && !updown && ext_en && ext_edge && run;
	wire capture_evt = capture_mode && ext_edge && run;
	wire reload_evt = overflow || underflow || edge_reload;
	wire irq_evt = (reload_evt && !updown) || capture_evt;

	// Decoded register accesses.
	wire wr_ctrl = I_WRITE && (I_ADDR == rct_pkg::ADDR_CTRL);
	wire wr_reload = I_WRITE && (I_ADDR == rct_pkg::ADDR_RELOAD);
	wire wr_lo = I_WRITE && (I_ADDR == rct_pkg::ADDR_COUNT_LO);
	wire wr_hi = I_WRITE && (I_ADDR == rct_pkg::ADDR_COUNT_HI);
	wire rd_status = I_READ && (I_ADDR == rct_pkg::ADDR_STATUS);

	// Next counter value; a reload or a software write takes priority.
	logic [WIDTH-1:0] next_count;
	always_comb begin
		next_count = count;
		if (wr_lo) begin
			next_count = {count[WIDTH-1:8], I_WDATA[7:0]};
		end else if (wr_hi) begin
			next_count = {I_WDATA[WIDTH-9:0], count[7:0]};
		end else if (capture_mode && overflow) begin
			next_count = ZERO;
		end else if (underflow) begin
			next_count = TOP;
		end else if (reload_evt) begin
			next_count = reload;
		end else if (tick) begin
			next_count = dir_up ? count + 1'b1 : count - 1'b1;
		end
	end

	// Read data mux; unmapped addresses answer zero.
	logic [15:0] next_rdata;
	always_comb begin
		next_rdata = 16'h0000;
		if (I_READ) begin
			case (I_ADDR)
				rct_pkg::ADDR_CTRL: next_rdata = {10'h000, ctrl};
				rct_pkg::ADDR_RELOAD: next_rdata = 16'(reload);
				rct_pkg::ADDR_COUNT_LO: next_rdata = {8'h00, count[7:0]};
				rct_pkg::ADDR_COUNT_HI: next_rdata = {8'h00, count[15:8]};
				rct_pkg::ADDR_STATUS: next_rdata = {13'h0000, dir_up,
					sticky_capture, sticky_reload};
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	// Divider state: run while enabled, restart the phase when disabled.
	always_comb begin
		case (state)
			RCT_IDLE: next_state = run ? RCT_RUN : RCT_IDLE;
			RCT_RUN: next_state = run ? RCT_RUN : RCT_IDLE;
			default: next_state = RCT_IDLE;
		endcase
	end

	rct_pin_sync u_sync (
		.i_clock(I_CLOCK),
		.i_reset(I_RESET),
		.i_pin(I_TIMER_EXTERNAL_INPUT),
		.o_pin(pin)
	);

	// Control and divider registers.
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			ctrl <= rct_pkg::CTRL_RESET;
			state <= RCT_IDLE;
			div <= rct_pkg::DIV_RESET;
		end else begin
			state <= next_state;
			if (wr_ctrl) begin
				ctrl <= I_WDATA[5:0];
			end
			div <= (state != RCT_RUN || div == div_last) ? rct_pkg::DIV_RESET
				: div + 1'b1;
		end
	end

	// Counter and reload/capture register; a capture wins over a write.
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			count <= WIDTH'(rct_pkg::COUNT_RESET);
			reload <= WIDTH'(rct_pkg::RELOAD_RESET);
		end else begin
			count <= next_count;
			if (capture_evt) begin
				reload <= count;
			end else if (wr_reload) begin
				reload <= I_WDATA[WIDTH-1:0];
			end
		end
	end

	// Sticky event bits: a new event wins over the clear-on-read.
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) begin
			sticky_reload <= 1'b0;
			sticky_capture <= 1'b0;
			O_IRQ <= 1'b0;
			O_RDATA <= 16'h0000;
			O_TIMER_COUNT_VALUE <= WIDTH'(rct_pkg::COUNT_RESET);
		end else begin
			sticky_reload <= reload_evt || (sticky_reload && !rd_status);
			sticky_capture <= capture_evt || (sticky_capture && !rd_status);
			O_IRQ <= irq_evt;
			O_RDATA <= next_rdata;
			O_TIMER_COUNT_VALUE <= next_count;
		end
	end
endmodule

// File: bench/rct_timer_monitor.sv
/*
 * Port checker for the reload/capture timer.
 * Assumes it is bound to rct_timer and sees only its ports.
 */
`timescale 1ns/1ps
module rct_timer_monitor #(
	parameter int WIDTH = 16
) (
	// Watched ports.
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	input wire logic [3:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WRITE,
	input wire logic I_READ,
	input wire logic [15:0] O_RDATA,
	input wire logic O_IRQ,
	input wire logic [WIDTH-1:0] O_TIMER_COUNT_VALUE
);
	logic [5:0] ctrl;
	logic [15:0] c;
	logic run;
	logic cap;
	logic ud;
	logic ext;
	// The mode bits are not on the ports, so a shadow copy follows each control write.
	always_ff @(posedge I_CLOCK) begin
		if (I_RESET) ctrl <= 6'h00;
		else if (I_WRITE && I_ADDR == rct_pkg::ADDR_CTRL) ctrl <= I_WDATA[5:0];
	end
	// Decoded mode bits.
	assign c = 16'(O_TIMER_COUNT_VALUE);
	assign run = ctrl[rct_pkg::CTRL_RUN];
	assign cap = ctrl[rct_pkg::CTRL_CAPTURE];
	assign ud = ctrl[rct_pkg::CTRL_UPDOWN];
	assign ext = ctrl[rct_pkg::CTRL_EXT_EN];
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);
	sequence rd_lo; I_READ && I_ADDR == rct_pkg::ADDR_COUNT_LO; endsequence
	sequence rd_hi; I_READ && I_ADDR == rct_pkg::ADDR_COUNT_HI; endsequence
	rdata_idle_a: assert property (!$past(I_READ) |-> O_RDATA == 16'h0000)
		else $error("read data not idle");
	count_lo_a: assert property (rd_lo |=> O_RDATA == {8'h00, $past(c[7:0])})
		else $error("low byte read wrong");
	count_hi_a: assert property (rd_hi |=> O_RDATA == {8'h00, $past(c[15:8])})
		else $error("high byte read wrong");
	auto_step_a: assert property (run && !ud && !cap && !ext && $stable(ctrl) && $changed(c)
		&& !$past(I_WRITE) |-> c == $past(c) + 16'h0001 || $past(c) == 16'hffff)
		else $error("auto count step wrong");
	cap_step_a: assert property (run && cap && $stable(ctrl) && $changed(c) && !$past(I_WRITE)
		|-> c == $past(c) + 16'h0001) else $error("capture count step wrong");
	updown_quiet_a: assert property (ud && !cap && $past(ud && !cap) |-> !O_IRQ)
		else $error("interrupt in up/down mode");
	halt_hold_a: assert property (!run && !ext && !$past(I_WRITE) |-> $stable(c))
		else $error("count moved while stopped");
	idle_irq_a: assert property (ctrl == 6'h00 && $past(ctrl) == 6'h00 |-> !O_IRQ)
		else $error("interrupt while idle");
endmodule
bind rct_timer rct_timer_monitor #(.WIDTH(WIDTH)) i_rct_timer_monitor (.I_CLOCK(I_CLOCK),
	.I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WRITE(I_WRITE), .I_READ(I_READ),
	.O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_TIMER_COUNT_VALUE(O_TIMER_COUNT_VALUE));

// File: bench/tb_top.sv
/*
 * Self-checking bench for the reload/capture timer.
 * Assumes a 100 MHz clock and the port checker bound to the design.
 */
`timescale 1ns/1ps
module tb_top;
	logic I_CLOCK = 1'b0;
	logic I_RESET = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic pin = 1'b0;
	logic irq;
	logic [15:0] rdata;
	logic [15:0] cnt;
	int failures = 0;
	int samples_checked = 0;
	int irqs = 0;
	rct_timer i_rct_timer (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WRITE(wr_s), .I_READ(rd_s), .O_RDATA(rdata), .I_TIMER_EXTERNAL_INPUT(pin),
		.O_IRQ(irq), .O_TIMER_COUNT_VALUE(cnt));
	// Clock, and a tally of interrupt pulses so scenarios can compare counts.
	always #5 I_CLOCK = ~I_CLOCK;
	always @(posedge I_CLOCK) if (irq === 1'b1) irqs++;
	task automatic stop_test;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge I_CLOCK);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge I_CLOCK);
		wr_s <= 1'b0;
		#1;
	endtask
	// Read data is valid only in the cycle after the strobe, so it is sampled there.
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
		@(posedge I_CLOCK);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge I_CLOCK);
		rd_s <= 1'b0;
		#1;
		chk(n, e, rdata);
	endtask
	// Waits for the next count change, bounded, and checks value and spacing.
	task automatic step(input logic [15:0] e, input int gap);
		int n;
		logic [15:0] v;
		v = cnt;
		n = 0;
		while (cnt === v && n < 40) begin
			@(posedge I_CLOCK);
			#1;
			n++;
		end
		chk("count", e, cnt);
		if (gap > 0) chk("spacing", 16'(gap), 16'(n));
	endtask
	task automatic t_reset;
		for (int a = 0; a < 4; a++) rd(4'(a), 16'h0000, "reset value");
		rd(4'h5, 16'h0000, "unmapped");
	endtask
	task automatic t_auto;
		wr(rct_pkg::ADDR_RELOAD, 16'h1234);
		wr(rct_pkg::ADDR_COUNT_HI, 16'h00ff);
		wr(rct_pkg::ADDR_COUNT_LO, 16'h00fe);
		wr(rct_pkg::ADDR_CTRL, 16'h0001);
		step(16'hffff, 0);
		step(16'h1234, 12);
		step(16'h1235, 12);
		chk("reload irq", 16'h0001, 16'(irqs));
		rd(rct_pkg::ADDR_COUNT_LO, 16'h0035, "count low");
		rd(rct_pkg::ADDR_COUNT_HI, 16'h0012, "count high");
	endtask
	// Pin low counts down to the reload value and wraps to the top; pin high wraps back.
	task automatic t_updown;
		int base;
		wr(rct_pkg::ADDR_CTRL, 16'h0000);
		wr(rct_pkg::ADDR_RELOAD, 16'h0005);
		wr(rct_pkg::ADDR_COUNT_LO, 16'h0006);
		wr(rct_pkg::ADDR_COUNT_HI, 16'h0000);
		wr(rct_pkg::ADDR_CTRL, 16'h0005);
		base = irqs;
		step(16'h0005, 0);
		step(16'hffff, 12);
		@(posedge I_CLOCK);
		pin <= 1'b1;
		step(16'h0005, 0);
		chk("up/down irq", 16'(base), 16'(irqs));
	endtask
	task automatic t_capture;
		int base;
		@(posedge I_CLOCK);
		pin <= 1'b0;
		wr(rct_pkg::ADDR_CTRL, 16'h0013);
		step(16'h0006, 0);
		base = irqs;
		@(posedge I_CLOCK);
		pin <= 1'b1;
		repeat (8) @(posedge I_CLOCK);
		chk("capture irq", 16'(base + 1), 16'(irqs));
		rd(rct_pkg::ADDR_RELOAD, 16'h0006, "captured");
	endtask
	// A falling pin edge reloads in auto mode; status clears on read; the prescaler slows ticks.
	task automatic t_edge;
		int base;
		wr(rct_pkg::ADDR_CTRL, 16'h0000);
		wr(rct_pkg::ADDR_RELOAD, 16'h4321);
		wr(rct_pkg::ADDR_COUNT_HI, 16'h0001);
		wr(rct_pkg::ADDR_COUNT_LO, 16'h0000);
		wr(rct_pkg::ADDR_CTRL, 16'h0009);
		base = irqs;
		@(posedge I_CLOCK);
		pin <= 1'b0;
		repeat (8) @(posedge I_CLOCK);
		#1;
		chk("edge reload", 16'h4321, cnt);
		chk("edge irq", 16'(base + 1), 16'(irqs));
		rd(rct_pkg::ADDR_STATUS, 16'h0007, "status sticky");
		rd(rct_pkg::ADDR_STATUS, 16'h0004, "status cleared");
		wr(rct_pkg::ADDR_CTRL, 16'h0000);
		wr(rct_pkg::ADDR_COUNT_LO, 16'h0000);
		wr(rct_pkg::ADDR_CTRL, 16'h0021);
		step(16'h4301, 0);
		step(16'h4302, rct_pkg::TICK_DIV_PRE);
	endtask
	initial begin
		repeat (20) @(posedge I_CLOCK);
		I_RESET <= 1'b0;
		t_reset;
		t_auto;
		t_updown;
		t_capture;
		t_edge;
		stop_test;
	end
	// The scenarios need well under a thousand cycles.
	initial begin
		repeat (3000) @(posedge I_CLOCK);
		failures++;
		stop_test;
	end
endmodule
